// ==== verif/swh_bus_dev.sv ====
// bus device model: pulled-up line that answers zero after a release
`timescale 1ns/1ps
module swh_bus_dev
(
    input  wire logic mclk,
    input  wire logic bus_oe,
    input  wire logic answer_low,
    output wire logic bus_line
);
    logic       oe_q   = 1'b0;
    logic [11:0] pull_q = 12'h0;
    // released line reads high through the pull-up, never a held value
    // answer spans the default sample point of a bit slot
    assign bus_line = !(bus_oe || pull_q != 12'h0);
    always @(posedge mclk)
    begin
        oe_q <= bus_oe;
        if (oe_q && !bus_oe && answer_low)
            pull_q <= 12'h800;
        else if (pull_q != 12'h0)
            pull_q <= pull_q - 12'h1;
    end
endmodule

// ==== verif/swh_checker.sv ====
// pin-level assertions for the slot handshake block
`timescale 1ns/1ps
module swh_checker
#(
    parameter int SLOT_CYC    = 15000,
    parameter int OD_SLOT_CYC = 1500,
    parameter int BITLOW_CYC  = 250,
    parameter int RSTLOW_CYC  = 120000,
    parameter int RSTBUSY_CYC = 240000
)
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic slot_enable_n,
    input wire logic chain_in2,
    input wire logic bus_out,
    input wire logic bus_oe,
    input wire logic out1_busy1_n,
    input wire logic out2_busy2_n,
    input wire logic enable_chain_out,
    input wire logic overdrive_flag
);
    logic [19:0] oe_cnt_q;
    logic [19:0] run_cnt_q;
    logic        rst_slot_q;
    logic        od_slot_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // run_cnt_q saturates so a long idle never wraps into a short busy
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            oe_cnt_q   <= 20'h0;
            run_cnt_q  <= 20'hfffff;
            rst_slot_q <= 1'b0;
            od_slot_q  <= 1'b0;
        end
        else
        begin
            oe_cnt_q   <= bus_oe ? oe_cnt_q + 20'h1 : 20'h0;
            run_cnt_q  <= $rose(bus_oe) ? 20'h1 : run_cnt_q + {19'h0, run_cnt_q != 20'hfffff};
            rst_slot_q <= $rose(bus_oe) ? 1'b0 : ((oe_cnt_q > SLOT_CYC) ? 1'b1 : rst_slot_q);
            // speed of the last slot; a later toggle must not change its busy minimum
            od_slot_q  <= $rose(bus_oe) ? overdrive_flag : od_slot_q;
        end
    end
    a_open_drain: assert property (bus_out == 1'b0)
        else $error("bus line driven high");
    a_busy1_start: assert property ($rose(bus_oe) |=> !out1_busy1_n)
        else $error("first output not busy at slot start");
    a_busy2_start: assert property ($rose(bus_oe) |-> ##[1:4] !out2_busy2_n)
        else $error("second output not busy at slot start");
    a_low_length: assert property ($fell(bus_oe) |-> oe_cnt_q inside {[BITLOW_CYC:BITLOW_CYC+1],
        [SLOT_CYC-1:SLOT_CYC+1], [RSTLOW_CYC:RSTLOW_CYC+1]}) else $error("bus low time wrong");
    a_slot_busy_min: assert property ($rose(out2_busy2_n) |-> run_cnt_q >= (od_slot_q ? OD_SLOT_CYC : SLOT_CYC) - 1)
        else $error("slot busy too short");
    a_reset_busy_min: assert property ($rose(out2_busy2_n) && rst_slot_q |-> run_cnt_q >= RSTBUSY_CYC - 1)
        else $error("reset busy too short");
    a_chain_enable: assert property (slot_enable_n [*4] |-> enable_chain_out)
        else $error("enable chain output low while idle");
    a_toggle_quiet: assert property ($changed(overdrive_flag) |-> !bus_oe && !$past(bus_oe))
        else $error("bus moved on speed toggle");
    a_pass_through: assert property ($rose(slot_enable_n) ##1 slot_enable_n [*5] |-> out2_busy2_n == chain_in2)
        else $error("second output not passing chain input");
endmodule
bind swh_top swh_checker #(.SLOT_CYC(SLOT_CYC), .OD_SLOT_CYC(OD_SLOT_CYC), .BITLOW_CYC(BITLOW_CYC),
    .RSTLOW_CYC(RSTLOW_CYC),
    .RSTBUSY_CYC(RSTBUSY_CYC)) swh_checker_inst (.mclk(mclk), .srst(srst), .slot_enable_n(slot_enable_n),
    .chain_in2(chain_in2), .bus_out(bus_out), .bus_oe(bus_oe), .out1_busy1_n(out1_busy1_n),
    .out2_busy2_n(out2_busy2_n), .enable_chain_out(enable_chain_out), .overdrive_flag(overdrive_flag));

// ==== verif/testbench.sv ====
// host-side bench for the slot handshake block
`timescale 1ns/1ps
module testbench;
    logic   mclk    = 1'b0;
    logic   srst    = 1'b1;
    logic   en_n    = 1'b1;
    logic   strobe  = 1'b1;
    logic   rreq_n  = 1'b1;
    logic   ans_low = 1'b0;
    logic   c1      = 1'b0;
    logic   c2      = 1'b1;
    wire    line, b_out, b_oe, o1, o2, eco, odf;
    integer bad_count   = 0;
    integer comparisons = 0;
    integer k;
    always #2 mclk = ~mclk;
    // default sample and release points; reset low above slot length so the checker tells them apart
    swh_top #(.SLOT_CYC(2400), .RSTLOW_CYC(3000), .PRES_CYC(3500), .RSTBUSY_CYC(6000), .BSY2_CYC(2))
        swh_top_inst (.mclk(mclk), .srst(srst), .slot_enable_n(en_n), .data_strobe(strobe),
        .reset_request_n(rreq_n), .chain_in1(c1), .chain_in2(c2), .bus_in(line), .bus_out(b_out),
        .bus_oe(b_oe), .out1_busy1_n(o1), .out2_busy2_n(o2), .enable_chain_out(eco), .overdrive_flag(odf));
    swh_bus_dev swh_bus_dev_inst (.mclk(mclk), .bus_oe(b_oe), .answer_low(ans_low), .bus_line(line));
    task chk(input logic got, input logic exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp)
            begin
                bad_count = bad_count + 1;
                $display("Error at %0t: output mismatch", $time);
            end
        end
    endtask
    task end_sim;
        begin
            $display("mismatches %0d comparisons %0d", bad_count, comparisons);
            if (bad_count == 0 && comparisons > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    // slot kind from strobe and reset request; res is the expected result level
    task do_slot(input logic s, input logic r, input logic low, input logic res);
        begin
            strobe  <= s;
            rreq_n  <= r;
            ans_low <= low;
            repeat (3) @(posedge mclk);
            en_n <= 1'b0;
            repeat (9) @(posedge mclk);
            chk(o1, 1'b0);
            chk(o2, 1'b0);
            chk(eco, 1'b0);
            k = 0;
            while (o2 !== 1'b1 && k < 7000)
            begin
                @(posedge mclk);
                k = k + 1;
            end
            if (k >= 7000)
            begin
                bad_count = bad_count + 1;
                end_sim;
            end
            strobe <= 1'b0;
            repeat (6) @(posedge mclk);
            chk(o2, res);
            en_n <= 1'b1;
            repeat (6) @(posedge mclk);
            chk(o2, 1'b1);
        end
    endtask
    task do_toggle(input logic flag);
        begin
            strobe <= 1'b0;
            rreq_n <= 1'b0;
            repeat (3) @(posedge mclk);
            en_n <= 1'b0;
            repeat (9) @(posedge mclk);
            chk(odf, flag);
            chk(o2, flag);
            chk(b_oe, 1'b0);
            en_n <= 1'b1;
            repeat (6) @(posedge mclk);
        end
    endtask
    // chain inputs moved apart while idle; outside resets so chain detection is untouched
    task do_pass;
        begin
            c1 <= 1'b1;
            c2 <= 1'b0;
            repeat (6) @(posedge mclk);
            chk(o1, 1'b1);
            chk(o2, 1'b0);
            c1 <= 1'b0;
            c2 <= 1'b1;
            repeat (6) @(posedge mclk);
            chk(o1, 1'b0);
            chk(o2, 1'b1);
        end
    endtask
    initial
    begin
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        repeat (4) @(posedge mclk);
        do_slot(1'b1, 1'b1, 1'b0, 1'b1);
        do_slot(1'b1, 1'b1, 1'b1, 1'b0);
        do_slot(1'b0, 1'b1, 1'b0, 1'b0);
        do_slot(1'b1, 1'b0, 1'b1, 1'b0);
        do_slot(1'b1, 1'b0, 1'b0, 1'b1);
        do_toggle(1'b1);
        do_slot(1'b1, 1'b1, 1'b1, 1'b0);
        do_toggle(1'b0);
        do_slot(1'b1, 1'b1, 1'b1, 1'b0);
        do_pass;
        end_sim;
    end
endmodule

// ==== verilog/swh_defines.vh ====
// timing constants of the slot handshake block
`ifndef SWH_DEFINES_VH
`define SWH_DEFINES_VH

`define SWH_CLK_MHZ        250
`define SWH_CNT_W          20

// normal speed, in microseconds
`define SWH_T_SLOT_US      60
`define SWH_T_SAMPLE_US    8
`define SWH_T_BITLOW_US    1
`define SWH_T_RSTLOW_US    480
`define SWH_T_PRES_US      550
`define SWH_T_RSTBUSY_US   960
`define SWH_T_BSY2_US      2

// overdrive speed, in microseconds
`define SWH_T_OD_SLOT_US   6
`define SWH_T_OD_SAMPLE_US 2
`define SWH_T_OD_RSTLOW_US 48
`define SWH_T_OD_PRES_US   56
`define SWH_T_OD_RSTBUSY_US 96

// cycle counts, all least times, exact at integer MHz
`define SWH_CYC(us)        ((us) * `SWH_CLK_MHZ)

// one-hot states
`define SWH_S_IDLE         4'h1
`define SWH_S_LOW          4'h2
`define SWH_S_REL          4'h4
`define SWH_S_DONE         4'h8

`endif

// ==== verilog/swh_sync.v ====
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module swh_sync
#(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b1}}
)
(
    input  wire         mclk,
    input  wire         srst,
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);

    reg [W-1:0] meta_q;

    always @(posedge mclk)
    begin
        if (srst)
        begin
            meta_q <= INIT;
            dout   <= INIT;
        end
        else
        begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end

endmodule

// ==== verilog/swh_top.v ====
// slot handshake and bus timing of the single-wire slot generator
// Behaviour
// R1: host pulls slot_enable_n low to start every slot or bus reset.
// R2: out1_busy1_n low while slot runs, then follows chain_in1.
// R3: out2_busy2_n low while slot runs, then follows chain_in2.
// R4: after slot, strobe low drives out1 low if sampled bus was low.
// R5: after slot, strobe low drives out2 low if sampled bus was low.
// R6: slot_enable_n high makes out1 follow chain_in1 again.
// R7: slot_enable_n high makes out2 follow chain_in2 again.
// R8: host sets data_strobe to choose slot kind before the slot.
// R9: host pulls data_strobe low after the slot to ask the result.
// R10: host holds reset_request_n low before enable to ask a bus reset.
// R11: when not last in chain, enable_chain_out follows slot_enable_n.
// R12: bus line is open drain: only pulled low or released.
// R13: bus reset holds the line low at least 480 us, then releases; in overdrive the code holds it low only 48 us (OD_RSTLOW_CYC).
// R14: reset keeps both outputs busy at least 960 us from first fall; out2 goes busy only BSY2_CYC after it; in overdrive the code keeps them busy 96 us.
// R15: every slot samples at a fixed point; busy lasts at least 60 us; in overdrive the code keeps a slot busy only 6 us (OD_SLOT_CYC).
// R16: enable with strobe and reset request low toggles overdrive only.
// R17: host pins pass synchronisers; enable falling edge acts once.
`timescale 1ns/1ps
`include "swh_defines.vh"
module swh_top
#(
    parameter [`SWH_CNT_W-1:0] SLOT_CYC       = `SWH_CYC(`SWH_T_SLOT_US),
    parameter [`SWH_CNT_W-1:0] SAMPLE_CYC     = `SWH_CYC(`SWH_T_SAMPLE_US),
    parameter [`SWH_CNT_W-1:0] BITLOW_CYC     = `SWH_CYC(`SWH_T_BITLOW_US),
    parameter [`SWH_CNT_W-1:0] RSTLOW_CYC     = `SWH_CYC(`SWH_T_RSTLOW_US),
    parameter [`SWH_CNT_W-1:0] PRES_CYC       = `SWH_CYC(`SWH_T_PRES_US),
    parameter [`SWH_CNT_W-1:0] RSTBUSY_CYC    = `SWH_CYC(`SWH_T_RSTBUSY_US),
    parameter [`SWH_CNT_W-1:0] BSY2_CYC       = `SWH_CYC(`SWH_T_BSY2_US),
    parameter [`SWH_CNT_W-1:0] OD_SLOT_CYC    = `SWH_CYC(`SWH_T_OD_SLOT_US),
    parameter [`SWH_CNT_W-1:0] OD_SAMPLE_CYC  = `SWH_CYC(`SWH_T_OD_SAMPLE_US),
    parameter [`SWH_CNT_W-1:0] OD_RSTLOW_CYC  = `SWH_CYC(`SWH_T_OD_RSTLOW_US),
    parameter [`SWH_CNT_W-1:0] OD_PRES_CYC    = `SWH_CYC(`SWH_T_OD_PRES_US),
    parameter [`SWH_CNT_W-1:0] OD_RSTBUSY_CYC = `SWH_CYC(`SWH_T_OD_RSTBUSY_US)
)
(
    input  wire mclk,
    input  wire srst,
    input  wire slot_enable_n,
    input  wire data_strobe,
    input  wire reset_request_n,
    input  wire chain_in1,
    input  wire chain_in2,
    input  wire bus_in,
    output reg  bus_out,
    output reg  bus_oe,
    output reg  out1_busy1_n,
    output reg  out2_busy2_n,
    output reg  enable_chain_out,
    output reg  overdrive_flag
);

    wire [5:0] sync_w;
    wire       en_s;
    wire       ds_s;
    wire       rr_s;
    wire       c1_s;
    wire       c2_s;
    wire       bus_s;

    swh_sync #(.W(6), .INIT(6'h3f)) u_sync
    (
        .mclk (mclk),
        .srst (srst),
        .din  ({slot_enable_n, data_strobe, reset_request_n, chain_in1, chain_in2, bus_in}),
        .dout (sync_w)
    ); // see R17

    assign en_s  = sync_w[5];
    assign ds_s  = sync_w[4];
    assign rr_s  = sync_w[3];
    assign c1_s  = sync_w[2];
    assign c2_s  = sync_w[1];
    assign bus_s = sync_w[0];

    reg [3:0]            state_q;
    reg [`SWH_CNT_W-1:0] cnt_q;
    reg                  en_prev_q;
    reg                  is_rst_q;
    reg                  is_zero_q;
    reg                  hold_low_q;
    reg                  report_q;
    reg                  down_seen_q;
    reg                  last_q;

    // bit slots of kind one release early so the far device can answer
    wire                  en_fall = en_prev_q & ~en_s; // see R17
    wire [`SWH_CNT_W-1:0] low_len;
    wire [`SWH_CNT_W-1:0] busy_len;
    wire [`SWH_CNT_W-1:0] samp_at;

    assign low_len  = is_rst_q  ? (overdrive_flag ? OD_RSTLOW_CYC : RSTLOW_CYC) :
                      is_zero_q ? (overdrive_flag ? OD_SLOT_CYC : SLOT_CYC) : BITLOW_CYC; // see R13
    assign busy_len = is_rst_q  ? (overdrive_flag ? OD_RSTBUSY_CYC : RSTBUSY_CYC) :
                      (overdrive_flag ? OD_SLOT_CYC : SLOT_CYC); // see R14, R15
    assign samp_at  = is_rst_q  ? (overdrive_flag ? OD_PRES_CYC : PRES_CYC) :
                      (overdrive_flag ? OD_SAMPLE_CYC : SAMPLE_CYC); // see R15

    // the last device in the chain ignores its chain inputs while enabled
    wire pass1 = (last_q & ~en_s) ? 1'b1 : c1_s;
    wire pass2 = (last_q & ~en_s) ? 1'b1 : c2_s;
    wire busy  = (state_q == `SWH_S_LOW) | (state_q == `SWH_S_REL);

    reg out1_d;
    reg out2_d;

    always @*
    begin
        out1_d = pass1; // see R6
        out2_d = pass2; // see R7
        if (busy)
        begin
            out1_d = 1'b0; // see R2
            // reset busy keeps the second output up for a short while
            if (is_rst_q && cnt_q < BSY2_CYC)
                out2_d = pass2;
            else
                out2_d = 1'b0; // see R3
        end
        else if (state_q == `SWH_S_DONE && report_q && hold_low_q)
        begin
            out1_d = 1'b0; // see R4
            out2_d = 1'b0; // see R5
        end
    end

    always @(posedge mclk)
    begin
        if (srst)
        begin
            state_q          <= `SWH_S_IDLE;
            cnt_q            <= {`SWH_CNT_W{1'b0}};
            en_prev_q        <= 1'b1;
            is_rst_q         <= 1'b0;
            is_zero_q        <= 1'b0;
            hold_low_q       <= 1'b0;
            report_q         <= 1'b0;
            down_seen_q      <= 1'b0;
            last_q           <= 1'b0;
            bus_out          <= 1'b0;
            bus_oe           <= 1'b0;
            out1_busy1_n     <= 1'b1;
            out2_busy2_n     <= 1'b1;
            enable_chain_out <= 1'b1;
            overdrive_flag   <= 1'b0;
        end
        else
        begin
            en_prev_q        <= en_s;
            bus_out          <= 1'b0; // see R12
            out1_busy1_n     <= out1_d;
            out2_busy2_n     <= out2_d;
            enable_chain_out <= last_q ? 1'b1 : en_s; // see R11
            case (state_q)
                `SWH_S_IDLE:
                begin
                    cnt_q <= {`SWH_CNT_W{1'b0}};
                    if (en_fall)
                    begin
                        is_rst_q  <= ~rr_s;
                        is_zero_q <= ~ds_s;
                        if (~ds_s && ~rr_s)
                        begin
                            // result reads low when overdrive has just been turned off
                            overdrive_flag <= ~overdrive_flag; // see R16
                            hold_low_q     <= overdrive_flag;
                            report_q       <= 1'b1;
                            state_q        <= `SWH_S_DONE;
                        end
                        else
                        begin
                            bus_oe      <= 1'b1; // see R12
                            down_seen_q <= 1'b0;
                            report_q    <= 1'b0;
                            hold_low_q  <= 1'b0;
                            state_q     <= `SWH_S_LOW;
                        end
                    end
                end
                `SWH_S_LOW:
                begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == samp_at)
                        hold_low_q <= ~bus_s; // see R15
                    if (is_rst_q && ~c1_s)
                        down_seen_q <= 1'b1;
                    if (cnt_q >= low_len - 1'b1)
                    begin
                        bus_oe  <= 1'b0; // see R13
                        state_q <= `SWH_S_REL;
                    end
                end
                `SWH_S_REL:
                begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == samp_at)
                        hold_low_q <= ~bus_s; // see R15
                    if (is_rst_q && ~c1_s)
                        down_seen_q <= 1'b1;
                    if (cnt_q >= busy_len - 1'b1)
                    begin
                        // no busy seen from behind during reset means we end the chain
                        if (is_rst_q)
                            last_q <= ~down_seen_q;
                        state_q <= `SWH_S_DONE; // see R14, R15
                    end
                end
                `SWH_S_DONE:
                begin
                    if (en_s)
                    begin
                        report_q <= 1'b0;
                        state_q  <= `SWH_S_IDLE; // see R6, R7
                    end
                    else if (~ds_s)
                        report_q <= 1'b1; // see R4, R5
                end
                default:
                begin
                    bus_oe  <= 1'b0;
                    state_q <= `SWH_S_IDLE;
                end
            endcase
        end
    end

endmodule
